// file: bench/edf_fifo_config_properties.sv
`timescale 1ns/100ps
module edf_cfg_chk
    import edf_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic rst_n, // reset
    input wire logic [3:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // wdata
    input wire logic reg_wr, // write
    input wire logic reg_rd, // read
    input wire logic [31:0] reg_rdata, // rdata
    input wire edf_desc_req_s desc_req, // status in
    input wire edf_desc_flags_s desc_flags, // flags
    input wire logic rx_overflow, // overflow
    input wire logic [7:0] rx_discard_cnt, // discards
    input wire edf_fifo_state_s fifo_state, // fifo
    input wire logic tx_start, // start
    input wire logic [9:0] tx_fifo_size, // tx depth
    input wire logic [9:0] rx_fifo_size, // rx depth
    input wire logic [12:0] tx_thresh_bytes // threshold
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence ctr_read;
        reg_rd && reg_addr == 4'h4 && !rx_overflow;
    endsequence
    chk_tx_flag_clean:
    assert property (desc_req.tx_desc_write && desc_req.status[15:8] == 8'h00
        |=> !desc_flags.tx_desc_error_flag) else $error("tx flag set");
    chk_rx_flag_clean:
    assert property (desc_req.rx_desc_write && desc_req.status[7:0] == 8'h00
        |=> !desc_flags.rx_desc_error_flag) else $error("rx flag set");
    chk_thresh_scale:
    assert property (reg_wr && reg_addr == 4'h8 |=>
        tx_thresh_bytes == {$past(reg_wdata[10:0]), 2'b00})
        else $error("threshold bytes wrong");
    chk_sf_hold:
    assert property (tx_thresh_bytes == 13'h0 && !fifo_state.tx_frame_written
        && fifo_state.tx_level < tx_fifo_size |=> !tx_start)
        else $error("early start");
    chk_frame_start:
    assert property (fifo_state.tx_frame_written |=> tx_start)
        else $error("no start on frame");
    chk_full_start:
    assert property (fifo_state.tx_level >= tx_fifo_size |=> tx_start)
        else $error("no start on full");
    chk_ctr_clear:
    assert property (ctr_read ##1 !rx_overflow ##1 ctr_read
        |=> reg_rdata == 32'h0) else $error("counter not cleared");
    chk_depth_zero:
    assert property (reg_rd && reg_addr == 4'hc |=>
        reg_rdata[31:9] == 23'h0 && reg_rdata[7:1] == 7'h00)
        else $error("depth reserved bits set");
    chk_depth_frozen:
    assert property (fifo_state.tx_active ##1 1'b1 |=>
        $stable(tx_fifo_size) && $stable(rx_fifo_size))
        else $error("depth changed while active");
endmodule : edf_cfg_chk

bind edf_fifo_config edf_cfg_chk u_chk (.ref_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .desc_req, .desc_flags,
    .rx_overflow, .rx_discard_cnt, .fifo_state, .tx_start, .tx_fifo_size,
    .rx_fifo_size, .tx_thresh_bytes);

// file: bench/edf_mac_model.sv
`timescale 1ns/100ps
module edf_mac_model
    import edf_pkg::*;
(
    input wire logic ref_clk, // clock
    output edf_desc_req_s desc_req, // status out
    output logic rx_overflow, // overflow pulse
    output logic [7:0] rx_discard_cnt, // discards
    output edf_fifo_state_s fifo_state // fifo state
);
    initial begin
        desc_req = '0;
        rx_overflow = 1'b0;
        rx_discard_cnt = 8'h00;
        fifo_state = '0;
    end
    task desc(input logic [15:0] s, input logic tx);
        @(posedge ref_clk);
        desc_req <= {s, tx, !tx};
        @(posedge ref_clk);
        desc_req <= {~s, 2'b00}; // stale status scrambled
    endtask : desc
    task ovf(input logic [7:0] n);
        @(posedge ref_clk);
        rx_overflow <= 1'b1;
        rx_discard_cnt <= n;
        @(posedge ref_clk);
        rx_overflow <= 1'b0;
        rx_discard_cnt <= ~n;
    endtask : ovf
    task fst(input logic [9:0] lvl, input logic fw, input logic tx,
             input logic rx);
        @(posedge ref_clk);
        fifo_state <= {lvl, fw, tx, rx};
    endtask : fst
endmodule : edf_mac_model

// file: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import edf_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, tx_start, rx_overflow;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [9:0] tx_fifo_size, rx_fifo_size;
    logic [12:0] tx_thresh_bytes;
    logic [7:0] rx_discard_cnt;
    edf_desc_req_s desc_req;
    edf_desc_flags_s desc_flags;
    edf_fifo_state_s fifo_state;
    int fails = 0;
    int total_checks = 0;
    edf_fifo_config u_edf_fifo_config (.ref_clk, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .desc_req, .desc_flags,
        .rx_overflow, .rx_discard_cnt, .fifo_state, .tx_start,
        .tx_fifo_size, .rx_fifo_size, .tx_thresh_bytes);
    edf_mac_model u_edf_mac_model (.ref_clk, .desc_req, .rx_overflow,
        .rx_discard_cnt, .fifo_state);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
    endtask : rd
    task dflag(input logic [15:0] s, input logic tx, input logic exp);
        u_edf_mac_model.desc(s, tx);
        @(negedge ref_clk);
        chk(tx ? desc_flags.tx_desc_error_flag
            : desc_flags.rx_desc_error_flag, exp);
    endtask : dflag
    task st(input logic [9:0] lvl, input logic fw, input logic exp);
        u_edf_mac_model.fst(lvl, fw, 1'b0, 1'b0);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(tx_start, exp);
    endtask : st
    task tally_and_finish;
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #8000;
        fails++;
        tally_and_finish;
    end
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(4'h0, 32'h0);
        chk(tx_fifo_size, 32'h100);
        chk(rx_fifo_size, 32'h100);
        wr(4'h0, 32'hffff_ffff);
        rd(4'h0, 32'h1f9f);
        wr(4'h0, 32'h0101);
        dflag(16'h0100, 1'b1, 1'b0);
        dflag(16'h0001, 1'b0, 1'b0);
        dflag(16'h8000, 1'b1, 1'b1);
        dflag(16'h0080, 1'b0, 1'b1);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h7ff);
        wr(4'h8, 32'h10);
        chk(tx_thresh_bytes, 32'h40);
        st(10'h040, 1'b0, 1'b0);
        st(10'h041, 1'b0, 1'b1);
        wr(4'h8, 32'h0);
        st(10'h0ff, 1'b0, 1'b0);
        st(10'h0ff, 1'b1, 1'b1);
        st(10'h100, 1'b0, 1'b1);
        wr(4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h101);
        chk(tx_fifo_size, 32'h200);
        chk(rx_fifo_size, 32'h200);
        wr(4'h8, 32'h50);
        st(10'h140, 1'b0, 1'b0);
        st(10'h141, 1'b0, 1'b1);
        u_edf_mac_model.fst(10'h0, 1'b0, 1'b1, 1'b0);
        wr(4'hc, 32'h0);
        chk(tx_fifo_size, 32'h200);
        u_edf_mac_model.ovf(8'h05);
        u_edf_mac_model.ovf(8'h03);
        rd(4'h4, 32'h8);
        rd(4'h4, 32'h0);
        u_edf_mac_model.ovf(8'h02);
        wr(4'h4, 32'h1234);
        rd(4'h4, 32'h2);
        u_edf_mac_model.ovf(8'h02);
        fork
            rd(4'h4, 32'h2);
            u_edf_mac_model.ovf(8'h07);
        join
        rd(4'h4, 32'h7);
        repeat (258) u_edf_mac_model.ovf(8'hff);
        rd(4'h4, 32'hffff);
        rd(4'h2, 32'h0);
        u_edf_mac_model.fst(10'h0, 1'b0, 1'b0, 1'b0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk(tx_fifo_size, 32'h100);
        chk(rx_fifo_size, 32'h100);
        rd(4'h4, 32'h0);
        wr(4'hc, 32'h101);
        u_edf_mac_model.fst(10'h0, 1'b0, 1'b0, 1'b1);
        wr(4'hc, 32'h0);
        chk(rx_fifo_size, 32'h200);
        chk(tx_fifo_size, 32'h200);
        tally_and_finish;
    end
endmodule : testbench

// file: core/edf_cfg.svh
`ifndef EDF_CFG_SVH
`define EDF_CFG_SVH

`define EDF_ADDR_W 4
`define EDF_OFS_COPY_MASK 4'h0
`define EDF_OFS_MISSED 4'h4
`define EDF_OFS_THRESH 4'h8
`define EDF_OFS_DEPTH 4'hc
`define EDF_COPY_MASK_BITS 16'h1f9f
`define EDF_COPY_MASK_RST 16'h0000
`define EDF_THRESH_W 11
`define EDF_THRESH_RST 11'h000
`define EDF_THRESH_SF 11'h000
`define EDF_DEPTH_TX_BIT 8
`define EDF_DEPTH_RX_BIT 0
`define EDF_MISSED_W 16
`define EDF_MISSED_MAX 16'hffff
`define EDF_FIFO_SMALL 10'h100
`define EDF_FIFO_LARGE 10'h200
`define EDF_LVL_W 10

`endif

// file: core/edf_fifo_config.sv
// Function
// RULE1: mask bit 0 copies status 15..8 to tx flag, 7..0 to rx flag
// RULE2: mask bit 1 hides that status source from the descriptor
// RULE3: copy mask resets to all zeros
// RULE4: keep a 16-bit missed-frame counter
// RULE5: receive overflow adds the discarded frame count to the counter
// RULE6: counter saturates and holds at ffff
// RULE7: reading the counter returns it and clears it
// RULE8: writes to the counter do nothing
// RULE9: threshold in bytes is four times the programmed value
// RULE10: start on level above threshold, fifo full, or frame written
// RULE11: value zero is store-and-forward, the reset setting
// RULE12: software writes zero to threshold bits 31..11; up to 80 defined
// RULE13: software selects 512-byte tx depth before thresholds of 256+
// RULE14: software changes threshold only while transmission is halted
// RULE15: depth bit 8 picks tx fifo 256 or 512 bytes, reset 256
// RULE16: depth bit 0 picks rx fifo 256 or 512 bytes, reset 256
// RULE17: depth changes are ignored once tx or rx has started
// RULE18: depth bits 31..9 and 7..1 read zero
// RULE19: overflow during a counter read lands in the cleared counter
// RULE20: reserved mask and threshold bits read zero, writes ignored
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
`include "edf_cfg.svh"

module edf_fifo_config
    import edf_pkg::*;
(
    input wire logic ref_clk, // 250 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic [`EDF_ADDR_W-1:0] reg_addr, // byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire edf_desc_req_s desc_req, // status to fold into descriptor
    output edf_desc_flags_s desc_flags, // descriptor error flags
    input wire logic rx_overflow, // receive overflow discard pulse
    input wire logic [7:0] rx_discard_cnt, // frames discarded then
    input wire edf_fifo_state_s fifo_state, // tx fifo and run state
    output logic tx_start, // start first transmission
    output logic [`EDF_LVL_W-1:0] tx_fifo_size, // effective tx depth
    output logic [`EDF_LVL_W-1:0] rx_fifo_size, // effective rx depth
    output logic [`EDF_THRESH_W+1:0] tx_thresh_bytes // threshold bytes
);

    logic [15:0] copy_mask_r;
    logic [`EDF_THRESH_W-1:0] thresh_r;
    logic depth_tx_r;
    logic depth_rx_r;
    logic depth_tx_eff_r;
    logic depth_rx_eff_r;
    logic [`EDF_MISSED_W-1:0] missed_r;
    logic [`EDF_MISSED_W-1:0] missed_nxt;
    logic [31:0] rdata_nxt;
    edf_run_e run_r;
    logic wr_mask;
    logic wr_thresh;
    logic wr_depth;
    logic rd_missed;
    logic [`EDF_MISSED_W-1:0] missed_base;
    logic [`EDF_THRESH_W+1:0] tx_level_ext;
    logic tx_start_nxt;

    function automatic logic [`EDF_LVL_W-1:0] fifo_size(input logic sel);
        fifo_size = sel ? `EDF_FIFO_LARGE : `EDF_FIFO_SMALL;
    endfunction : fifo_size

    function automatic logic any_hit(input logic [7:0] st,
                                     input logic [7:0] mask);
        any_hit = |(st & ~mask);
    endfunction : any_hit

    function automatic logic addr_hit(input logic [`EDF_ADDR_W-1:0] addr,
                                      input logic [`EDF_ADDR_W-1:0] ofs);
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    // add with saturation at the top of the counter range
    function automatic logic [`EDF_MISSED_W-1:0] sat_add(
        input logic [`EDF_MISSED_W-1:0] base,
        input logic [7:0] inc);
        logic [`EDF_MISSED_W:0] sum;
        sum = {1'b0, base} + {9'h000, inc};
        if (sum[`EDF_MISSED_W]) begin
            sat_add = `EDF_MISSED_MAX;
        end else begin
            sat_add = sum[`EDF_MISSED_W-1:0];
        end
    endfunction : sat_add

    assign wr_mask = reg_wr && addr_hit(reg_addr, `EDF_OFS_COPY_MASK);
    assign wr_thresh = reg_wr && addr_hit(reg_addr, `EDF_OFS_THRESH);
    assign wr_depth = reg_wr && addr_hit(reg_addr, `EDF_OFS_DEPTH);
    assign rd_missed = reg_rd && addr_hit(reg_addr, `EDF_OFS_MISSED);

    // status copy mask, reserved bits never stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            copy_mask_r <= `EDF_COPY_MASK_RST; // RULE3
        end else if (wr_mask) begin
            copy_mask_r <= reg_wdata[15:0] & `EDF_COPY_MASK_BITS; // RULE20
        end
    end

    // transmit descriptor error flag, held until the next descriptor write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            desc_flags.tx_desc_error_flag <= 1'b0;
        end else if (desc_req.tx_desc_write) begin
            desc_flags.tx_desc_error_flag <= any_hit(
                desc_req.status[15:8], copy_mask_r[15:8]); // RULE1 RULE2
        end
    end

    // receive descriptor error flag, held until the next descriptor write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            desc_flags.rx_desc_error_flag <= 1'b0;
        end else if (desc_req.rx_desc_write) begin
            desc_flags.rx_desc_error_flag <= any_hit(
                desc_req.status[7:0], copy_mask_r[7:0]); // RULE1 RULE2
        end
    end

    // threshold register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_r <= `EDF_THRESH_RST; // RULE11
        end else if (wr_thresh) begin
            thresh_r <= reg_wdata[`EDF_THRESH_W-1:0]; // RULE20
        end
    end

    // transmit depth bit as written by software
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_tx_r <= 1'b0;
        end else if (wr_depth) begin
            depth_tx_r <= reg_wdata[`EDF_DEPTH_TX_BIT];
        end
    end

    // receive depth bit as written by software
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_rx_r <= 1'b0;
        end else if (wr_depth) begin
            depth_rx_r <= reg_wdata[`EDF_DEPTH_RX_BIT];
        end
    end

    // run state: leaves idle when tx or rx starts, back at reset only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= EDF_IDLE;
        end else begin
            case (run_r)
                EDF_IDLE: begin
                    if (fifo_state.tx_active || fifo_state.rx_active) begin
                        run_r <= EDF_RUN;
                    end
                end
                EDF_RUN: run_r <= EDF_RUN;
                default: run_r <= EDF_IDLE;
            endcase
        end
    end

    // effective depth follows the register only before traffic starts;
    // the fifo pointers would tear if the size moved under live data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_tx_eff_r <= 1'b0; // RULE15
        end else if (run_r == EDF_IDLE && !fifo_state.tx_active
                     && !fifo_state.rx_active) begin // RULE17
            depth_tx_eff_r <= depth_tx_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            depth_rx_eff_r <= 1'b0; // RULE16
        end else if (run_r == EDF_IDLE && !fifo_state.tx_active
                     && !fifo_state.rx_active) begin // RULE17
            depth_rx_eff_r <= depth_rx_r;
        end
    end

    assign tx_fifo_size = fifo_size(depth_tx_eff_r); // RULE15
    assign rx_fifo_size = fifo_size(depth_rx_eff_r); // RULE16
    assign tx_thresh_bytes = {thresh_r, 2'b00}; // RULE9

    // transmit start decision
    // level widened to the threshold width so the compare is exact
    assign tx_level_ext = {3'b000, fifo_state.tx_level};

    always_comb begin
        tx_start_nxt = 1'b0;
        if (fifo_state.tx_frame_written) begin
            tx_start_nxt = 1'b1; // RULE10
        end
        if (fifo_state.tx_level >= tx_fifo_size) begin
            tx_start_nxt = 1'b1; // RULE10
        end
        // a zero threshold means store-and-forward: only a written frame or a full fifo starts
        if (thresh_r != `EDF_THRESH_SF) begin // RULE11
            if (tx_level_ext > tx_thresh_bytes) begin
                tx_start_nxt = 1'b1; // RULE9 RULE10
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_start <= 1'b0;
        end else begin
            tx_start <= tx_start_nxt;
        end
    end

    // missed-frame counter, saturating, clear on read; discards that
    // arrive with the read land in the cleared counter
    always_comb begin
        missed_base = missed_r;
        if (rd_missed) begin
            missed_base = '0; // RULE7
        end
        if (rx_overflow) begin
            missed_nxt = sat_add(missed_base, rx_discard_cnt); // RULE5 RULE6
        end else begin
            missed_nxt = missed_base; // RULE19
        end
    end

    // software writes never reach the counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            missed_r <= '0; // RULE4
        end else begin
            missed_r <= missed_nxt; // RULE8
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (reg_addr)
            `EDF_OFS_COPY_MASK: rdata_nxt = {16'h0000, copy_mask_r};
            `EDF_OFS_MISSED: rdata_nxt = {16'h0000, missed_r}; // RULE7
            `EDF_OFS_THRESH: rdata_nxt = {21'h000000, thresh_r}; // RULE20
            `EDF_OFS_DEPTH: begin
                rdata_nxt[`EDF_DEPTH_TX_BIT] = depth_tx_r; // RULE18
                rdata_nxt[`EDF_DEPTH_RX_BIT] = depth_rx_r;
            end
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : edf_fifo_config

// file: core/edf_pkg.sv
package edf_pkg;
    typedef struct packed {
        logic [15:0] status;
        logic tx_desc_write;
        logic rx_desc_write;
    } edf_desc_req_s;

    typedef struct packed {
        logic tx_desc_error_flag;
        logic rx_desc_error_flag;
    } edf_desc_flags_s;

    typedef struct packed {
        logic [9:0] tx_level;
        logic tx_frame_written;
        logic tx_active;
        logic rx_active;
    } edf_fifo_state_s;

    typedef enum logic [1:0] {
        EDF_IDLE = 2'b00,
        EDF_RUN = 2'b01
    } edf_run_e;
endpackage : edf_pkg
